// ---- nine_bit_addr_regs.vh ----
/*
  Register offsets, field positions and reset values of the nine-bit
  address extension of the serial port.
  Assumes inclusion by its bare name from the design file.
*/
`ifndef NINE_BIT_ADDR_REGS_VH
`define NINE_BIT_ADDR_REGS_VH

// ==========================================================================
// Offsets
`define RX_ADDRESS_REG_OFF  8'hc4
`define TX_ADDRESS_REG_OFF  8'hc8
`define LINE_CTRL_EXT_OFF   8'hcc
`define TX_HOLDING_REG_OFF  8'h00

// ==========================================================================
// Fields of line_control_extension
`define NINE_BIT_EN_BIT     0
`define ADDR_FILTER_EN_BIT  1
`define SEND_ADDR_REQ_BIT   2
`define TX_NINE_MODE_BIT    3

// ==========================================================================
// Reset values
`define TX_ADDRESS_RESET    8'h00
`define RX_ADDRESS_RESET    8'h00
`define LINE_CTRL_RESET     4'h0

// ==========================================================================
// Bus answers
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10

`endif

// ---- uart_nine_bit_address_mode.v ----
/*
  Nine-bit character extension of a serial port: register slave on
  AXI4-Lite, transmit character selection and receive address filtering.
  Assumes the rest of the port serialises tx characters, delivers
  received characters and owns the base character length field.
*/
`default_nettype none
`include "nine_bit_addr_regs.vh"

module uart_nine_bit_address_mode #(
  parameter ADDR_W = 8
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              tx_fifo_valid,
  input  wire [8:0]        tx_fifo_data,
  output reg               tx_fifo_pop,
  input  wire              tx_start_ready,
  output reg               tx_char_valid,
  output reg  [8:0]        tx_char,
  output reg               tx_holding_write,
  output reg  [8:0]        tx_holding_data,
  input  wire              rx_char_valid,
  input  wire [8:0]        rx_char,
  output reg               rx_fifo_write,
  output reg  [8:0]        rx_fifo_data,
  output reg               nine_bit_char_enable,
  output reg               rx_address_filter_enable,
  output reg               send_address_request,
  output reg               tx_nine_bit_holding_mode,
  output reg  [7:0]        tx_address_reg,
  output reg  [7:0]        rx_address_reg,
  output reg               rx_matched
);

  // ========================================================================
  // Register select codes
  localparam [1:0] SEL_HOLD   = 2'd0;
  localparam [1:0] SEL_RXADDR = 2'd1;
  localparam [1:0] SEL_TXADDR = 2'd2;
  localparam [1:0] SEL_NONE   = 2'd3;

  // ========================================================================
  // Address decode
  // Only the low byte is compared, so the map repeats above 0xff
  function [1:0] decode;
    input [ADDR_W-1:0] a;
    begin
      if (a[7:0] == `TX_HOLDING_REG_OFF) begin
        decode = SEL_HOLD;
      end else if (a[7:0] == `RX_ADDRESS_REG_OFF) begin
        decode = SEL_RXADDR;
      end else if (a[7:0] == `TX_ADDRESS_REG_OFF) begin
        decode = SEL_TXADDR;
      end else begin
        decode = SEL_NONE;
      end
    end
  endfunction

  // A word is mapped if decode knows it or it is the control word
  function is_mapped;
    input [ADDR_W-1:0] a;
    begin
      is_mapped = (decode(a) != SEL_NONE) ||
                  (a[7:0] == `LINE_CTRL_EXT_OFF);
    end
  endfunction

  reg              aw_held;
  reg              w_held;
  reg [ADDR_W-1:0] aw_addr;
  reg [31:0]       w_data;
  reg [3:0]        w_strb;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire wr_fire = aw_held & w_held & ~s_axi_bvalid;
  wire ctrl_hit = (aw_addr[7:0] == `LINE_CTRL_EXT_OFF);
  wire [1:0] wsel = decode(aw_addr);
  // Unmapped words answer with an error and change nothing
  wire wr_ok = is_mapped(aw_addr);

  // Request is honoured only in 9-bit mode with 8-bit holding
  wire send_live = send_address_request & nine_bit_char_enable &
                   ~tx_nine_bit_holding_mode;
  wire start_addr = send_live & tx_start_ready & ~tx_char_valid;
  wire start_data = ~send_live & tx_start_ready & ~tx_char_valid &
                    tx_fifo_valid;

  // ========================================================================
  // Write channel
  // Awready and wready stay low until the response is taken, so only
  // one write is ever in flight and the held word cannot be overrun
  always @(posedge aclk) begin
    tx_holding_write <= 1'b0;
    if (!aresetn) begin
      aw_held                  <= 1'b0;
      w_held                   <= 1'b0;
      aw_addr                  <= {ADDR_W{1'b0}};
      w_data                   <= 32'h00000000;
      w_strb                   <= 4'h0;
      s_axi_awready            <= 1'b1;
      s_axi_wready             <= 1'b1;
      s_axi_bvalid             <= 1'b0;
      s_axi_bresp              <= `RESP_OKAY;
      tx_address_reg           <= `TX_ADDRESS_RESET;
      rx_address_reg           <= `RX_ADDRESS_RESET;
      nine_bit_char_enable     <= 1'b0;
      rx_address_filter_enable <= 1'b0;
      send_address_request     <= 1'b0;
      tx_nine_bit_holding_mode <= 1'b0;
      tx_holding_data          <= 9'h000;
    end else begin
      if (aw_take) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      // Auto clear as the address character starts; a new set wins
      if (start_addr) begin
        send_address_request <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        if (ctrl_hit && w_strb[0]) begin
          nine_bit_char_enable     <= w_data[`NINE_BIT_EN_BIT];
          rx_address_filter_enable <= w_data[`ADDR_FILTER_EN_BIT];
          tx_nine_bit_holding_mode <= w_data[`TX_NINE_MODE_BIT];
          // Writing 0 is not a cancel; only hardware clears it
          if (w_data[`SEND_ADDR_REQ_BIT]) begin
            send_address_request <= 1'b1;
          end
        end else if (wsel == SEL_TXADDR && w_strb[0]) begin
          tx_address_reg <= w_data[7:0];
        end else if (wsel == SEL_RXADDR && w_strb[0]) begin
          rx_address_reg <= w_data[7:0];
        end else if (wsel == SEL_HOLD) begin
          tx_holding_write <= 1'b1;
          // Holding width follows the transmit mode
          if (nine_bit_char_enable && tx_nine_bit_holding_mode) begin
            tx_holding_data <= w_data[8:0];
          end else begin
            tx_holding_data <= {1'b0, w_data[7:0]};
          end
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Read channel
  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h00000000;
    if (s_axi_araddr[7:0] == `LINE_CTRL_EXT_OFF) begin
      next_rdata[3:0] = {tx_nine_bit_holding_mode, send_address_request,
                         rx_address_filter_enable, nine_bit_char_enable};
    end else if (decode(s_axi_araddr) == SEL_TXADDR) begin
      next_rdata[7:0] = tx_address_reg;
    end else if (decode(s_axi_araddr) == SEL_RXADDR) begin
      next_rdata[7:0] = rx_address_reg;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= is_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ========================================================================
  // Transmit character selection
  // A live address request (send_live) always goes before queued data, and
  // every character is followed by one idle cycle, which gives the
  // serialiser time to drop its ready before the next start
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_char_valid <= 1'b0;
      tx_char       <= 9'h000;
      tx_fifo_pop   <= 1'b0;
    end else begin
      tx_fifo_pop <= 1'b0;
      if (tx_char_valid) begin
        tx_char_valid <= 1'b0;
      end else if (start_addr) begin
        tx_char_valid <= 1'b1;
        tx_char       <= {1'b1, tx_address_reg};
      end else if (start_data) begin
        tx_char_valid <= 1'b1;
        tx_fifo_pop   <= 1'b1;
        if (!nine_bit_char_enable) begin
          tx_char <= {1'b0, tx_fifo_data[7:0]};
        end else if (tx_nine_bit_holding_mode) begin
          tx_char <= tx_fifo_data;
        end else begin
          tx_char <= {1'b0, tx_fifo_data[7:0]};
        end
      end
    end
  end

  // ========================================================================
  // Receive address filtering
  wire filter_on = rx_address_filter_enable & nine_bit_char_enable;
  wire is_addr   = rx_char[8];
  // The match state survives a mode change on purpose: software that
  // pauses filtering resumes with the same addressed node
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_matched    <= 1'b0;
      rx_fifo_write <= 1'b0;
      rx_fifo_data  <= 9'h000;
    end else begin
      rx_fifo_write <= 1'b0;
      if (rx_char_valid) begin
        if (!nine_bit_char_enable) begin
          rx_fifo_write <= 1'b1;
          rx_fifo_data  <= {1'b0, rx_char[7:0]};
        end else if (!filter_on) begin
          rx_fifo_write <= 1'b1;
          rx_fifo_data  <= rx_char;
        end else if (is_addr) begin
          // Address characters are consumed, not stored
          rx_matched <= (rx_char[7:0] == rx_address_reg);
        end else if (rx_matched) begin
          rx_fifo_write <= 1'b1;
          rx_fifo_data  <= rx_char;
        end
        // Data after a mismatching address is dropped here
      end
    end
  end

endmodule // uart_nine_bit_address_mode
`default_nettype wire

// ---- uart_nine_bit_address_mode_chk.sv ----
/* Checker of the nine-bit extension at its character and control ports.
   Assumes binding onto the design top, one clock domain. */
`default_nettype none
module uart_nine_bit_address_mode_chk (
  input wire logic       aclk, aresetn, tx_fifo_valid, tx_fifo_pop,
  input wire logic       tx_start_ready, tx_char_valid, rx_char_valid,
  input wire logic       rx_fifo_write, nine_bit_char_enable, rx_matched,
  input wire logic       rx_address_filter_enable, send_address_request,
  input wire logic       tx_nine_bit_holding_mode,
  input wire logic [8:0] tx_fifo_data, tx_char, rx_char, rx_fifo_data,
  input wire logic [7:0] tx_address_reg, rx_address_reg
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic       go, live, flt, hit, b9, r9;
  logic [7:0] lo, rlo;
  assign go = tx_start_ready & ~tx_char_valid;
  assign live = send_address_request & nine_bit_char_enable
              & ~tx_nine_bit_holding_mode;
  assign flt = nine_bit_char_enable & rx_address_filter_enable;
  assign hit = rx_char[7:0] == rx_address_reg;
  assign b9 = nine_bit_char_enable & tx_nine_bit_holding_mode
            & tx_fifo_data[8];
  assign r9 = nine_bit_char_enable & rx_char[8];
  assign lo = tx_fifo_data[7:0];
  assign rlo = rx_char[7:0];
  // ==========================================================
  // Transmit side
  a_addr_char: assert property (go && live |=> tx_char_valid &&
    tx_char == {1'b1, $past(tx_address_reg)}) else $error("bad address");
  a_req_clear: assert property (go && live |=>
    !send_address_request) else $error("request not cleared");
  a_data_char: assert property (go && !live && tx_fifo_valid |=>
    tx_char_valid && tx_fifo_pop && tx_char[7:0] == $past(lo))
    else $error("bad data char");
  a_bit_nine: assert property (go && !live && tx_fifo_valid |=>
    tx_char[8] == $past(b9)) else $error("bad ninth bit");
  a_req_ignored: assert property (go && send_address_request &&
    !live && !tx_fifo_valid |=> !tx_char_valid) else $error("bad request");
  a_char_gap: assert property (tx_char_valid |=>
    !tx_char_valid && !tx_fifo_pop) else $error("chars too close");
  // ==========================================================
  // Receive side; dropped characters must never reach the FIFO
  a_rx_pass: assert property (rx_char_valid && !flt |=>
    rx_fifo_write && rx_fifo_data == {$past(r9), $past(rlo)})
    else $error("bad received char");
  a_rx_addr: assert property (rx_char_valid && flt && rx_char[8] |=>
    !rx_fifo_write && rx_matched == $past(hit)) else $error("bad match");
  a_rx_data: assert property (rx_char_valid && flt && !rx_char[8] |=>
    rx_fifo_write == $past(rx_matched)) else $error("bad filtering");
  c_addr: cover property (go && live);
  c_pass: cover property (rx_char_valid && flt && rx_matched && !rx_char[8]);
  c_drop: cover property (rx_char_valid && flt && !rx_matched && !rx_char[8]);
endmodule // uart_nine_bit_address_mode_chk
bind uart_nine_bit_address_mode uart_nine_bit_address_mode_chk u_chk (
  .aclk, .aresetn, .tx_fifo_valid, .tx_fifo_pop, .tx_start_ready,
  .tx_char_valid, .rx_char_valid, .rx_fifo_write, .nine_bit_char_enable,
  .rx_matched, .rx_address_filter_enable, .send_address_request,
  .tx_nine_bit_holding_mode, .tx_fifo_data, .tx_char, .rx_char,
  .rx_fifo_data, .tx_address_reg, .rx_address_reg);
`default_nettype wire

// ---- serial_peer_model.sv ----
/* Far side: tx FIFO and serialiser feeding the block, line receiver.
   Assumes the bench sets stall and calls push and send_rx. */
`default_nettype none
module serial_peer_model (
  input wire logic       aclk, tx_fifo_pop, tx_char_valid,
  input wire logic [8:0] tx_char,
  output var logic       tx_fifo_valid, tx_start_ready, rx_char_valid,
  output var logic [8:0] tx_fifo_data, rx_char
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] fifo_q[$], sent_q[$], last;
  logic       stall;
  initial begin
    {tx_fifo_valid, tx_start_ready, rx_char_valid, stall} = 4'h0;
    {tx_fifo_data, rx_char, last} = 27'h0;
  end
  // ==========================================================
  // Stale head is inverted so data read from an empty FIFO never repeats the last popped character
  always @(posedge aclk) begin
    if (tx_fifo_pop) last = fifo_q.pop_front();
    if (tx_char_valid) sent_q.push_back(tx_char);
    tx_start_ready <= !stall;
    tx_fifo_valid <= fifo_q.size() > 0;
    tx_fifo_data <= fifo_q.size() > 0 ? fifo_q[0] : ~last;
  end
  task push(input logic [8:0] d);
    fifo_q.push_back(d);
  endtask
  task send_rx(input logic [8:0] d);
    @(posedge aclk);
    rx_char_valid <= 1'b1;
    rx_char <= d;
    @(posedge aclk);
    rx_char_valid <= 1'b0;
    rx_char <= ~d;
  endtask
endmodule // serial_peer_model
`default_nettype wire

// ---- test_uart_nine_bit_address_mode.sv ----
/* Bench of the nine-bit extension: bus tasks, scenarios, verdict.
   Assumes the peer model and checker are compiled first. */
`default_nettype none
module test_uart_nine_bit_address_mode;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, tx_fifo_valid, tx_fifo_pop;
  logic tx_start_ready, tx_char_valid, tx_holding_write, rx_char_valid;
  logic rx_fifo_write, rx_matched, nine_bit_char_enable;
  logic rx_address_filter_enable, send_address_request;
  logic tx_nine_bit_holding_mode;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [7:0] tx_address_reg, rx_address_reg;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [8:0] tx_fifo_data, tx_char, tx_holding_data, rx_char;
  logic [8:0] rx_fifo_data, hold_last, rxq[$];
  int err_count = 0, check_count = 0;
  uart_nine_bit_address_mode dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .tx_fifo_valid, .tx_fifo_data, .tx_fifo_pop, .tx_start_ready,
    .tx_char_valid, .tx_char, .tx_holding_write, .tx_holding_data,
    .rx_char_valid, .rx_char, .rx_fifo_write, .rx_fifo_data,
    .nine_bit_char_enable, .rx_address_filter_enable,
    .send_address_request, .tx_nine_bit_holding_mode, .tx_address_reg,
    .rx_address_reg, .rx_matched);
  serial_peer_model peer (.aclk, .tx_fifo_pop, .tx_char_valid, .tx_char,
    .tx_fifo_valid, .tx_start_ready, .rx_char_valid, .tx_fifo_data,
    .rx_char);
  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    if (rx_fifo_write) rxq.push_back(rx_fifo_data);
    if (tx_holding_write) hold_last <= tx_holding_data;
  end
  // ==========================================================
  // Bus and compare tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    {rdat, resp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  task wait_tx(input int n);
    for (int i = 0; i < 60 && peer.sent_q.size() < n; i++) @(posedge aclk);
  endtask
  // ==========================================================
  // Scenarios
  task t_regs;
    rd(8'hc8); chk(rdat, 32'h0);
    rd(8'hcc); chk(rdat, 32'h0);
    wr(8'hc8, 32'hffff_ffa5); rd(8'hc8); chk(rdat, 32'ha5);
    rd(8'h10); chk(32'(resp), 32'h2);
    wr(8'h10, 32'h1); chk(32'(resp), 32'h2);
  endtask
  task t_hold;
    wr(8'hcc, 32'h9); wr(8'h00, 32'h1c3); repeat (2) @(posedge aclk);
    chk(32'(hold_last), 32'h1c3);
    wr(8'hcc, 32'h1); wr(8'h00, 32'h1c3); repeat (2) @(posedge aclk);
    chk(32'(hold_last), 32'h0c3);
  endtask
  task t_ignore;
    logic [31:0] mode [2] = '{32'hd, 32'h4};
    logic [31:0] exp [2] = '{32'h1e7, 32'h0e7};
    for (int i = 0; i < 2; i++) begin
      peer.stall = 1'b1;
      peer.sent_q.delete();
      peer.push(9'h1e7);
      wr(8'hcc, mode[i]);
      peer.stall = 1'b0;
      wait_tx(1);
      chk(32'(peer.sent_q[0]), exp[i]);
    end
  endtask
  task t_send;
    peer.stall = 1'b1;
    peer.sent_q.delete();
    peer.push(9'h1e7);
    wr(8'hc8, 32'h5a); wr(8'hcc, 32'h5); repeat (4) @(posedge aclk);
    chk(32'(peer.sent_q.size()), 32'h0);
    peer.stall = 1'b0;
    wait_tx(2);
    chk(32'(peer.sent_q[0]), 32'h15a);
    chk(32'(peer.sent_q[1]), 32'h0e7);
    rd(8'hcc); chk(rdat, 32'h1);
  endtask
  task t_rx;
    logic [8:0] sq [6] = '{9'h142, 9'h011, 9'h143, 9'h033, 9'h142, 9'h022};
    wr(8'hcc, 32'h1);
    rxq.delete();
    peer.send_rx(9'h1ab); wr(8'hcc, 32'h2); peer.send_rx(9'h1ab);
    wr(8'hc4, 32'h42); wr(8'hcc, 32'h3);
    foreach (sq[i]) peer.send_rx(sq[i]);
    repeat (2) @(posedge aclk);
    chk(32'(rxq.size()), 32'h4);
    chk(32'(rxq[0]), 32'h1ab);
    chk(32'(rxq[1]), 32'h0ab);
    chk(32'(rxq[2]), 32'h011);
    chk(32'(rxq[3]), 32'h022);
  endtask
  task report_and_stop;
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs; t_hold; t_ignore; t_send; t_rx;
    report_and_stop;
  end
  initial begin
    repeat (5000) @(posedge aclk);
    err_count++;
    report_and_stop;
  end
endmodule // test_uart_nine_bit_address_mode
`default_nettype wire
